/* core/lps_pkg.sv */
/*
 Constants and carrier types of the low-power mode sequencer.
 Assumes one 200 MHz clock and an APB register port.
*/
// Functional notes
// [R01] Backup needs key write plus deep sleep.
// [R02] Regulator-off request taken only with key.
// [R03] Backup: regulator and core supply off.
// [R04] Enabled pin transition or alarm exits backup.
// [R05] I/O lines held throughout backup.
// [R06] Backup wake resets core, I/O pulled-up inputs.
// [R07] Wake restores core and SRAM supplies.
// [R08] Wait entry: request, low-power bit, flash 0x.
// [R09] Wait stops core, peripheral, memory clocks; the code leaves periph_clk_en as written.
// [R10] Software wait entry order, poll clock ready.
// [R11] Software should wait for RC enable clear.
// [R12] Flash mode in wait follows flash select.
// [R13] Fast startup in wait reclocks core.
// [R14] Wait resume under ten microseconds.
// [R15] Sleep stops only the core clock.
// [R16] Sleep on wait-for-interrupt, both selects 0.
// [R17] Enabled interrupt wakes sleep.
// [R18] Source select, divider, peripheral gating.
// [R19] Wake runs from RC; PLL stays off.
// [R20] Regulator disable separate from backup.
// [R21] Low level on 19 inputs: fast startup; the code takes all 20 wake sources.
// [R22] Fast startup restarts RC, core clock.
package lps_pkg;
	localparam logic [7:0] OFS_SUPPLY_CMD = 8'h00;
	localparam logic [7:0] OFS_SUPPLY_MODE = 8'h04;
	localparam logic [7:0] OFS_WAKE_EN = 8'h08;
	localparam logic [7:0] OFS_FAST_CFG = 8'h0C;
	localparam logic [7:0] OFS_OSC_CFG = 8'h10;
	localparam logic [7:0] OFS_PERIPH_GATE = 8'h14;
	localparam logic [7:0] OFS_STATUS = 8'h18;
	localparam logic [7:0] SUPPLY_KEY = 8'hA5;
	localparam int KEY_POS = 24;
	localparam int REG_OFF_POS = 2;
	localparam int DEBOUNCE_POS = 20;
	localparam int LOW_POWER_POS = 20;
	localparam int FLASH_SEL_POS = 21;
	localparam int WAIT_REQ_POS = 1;
	localparam int CLK_SRC_POS = 2;
	localparam int PLL_EN_POS = 4;
	localparam int CLK_DIV_POS = 5;
	localparam logic [1:0] SRC_FAST_RC = 2'h0;
	localparam logic [7:0] OSC_RESET = 8'h01;
	localparam int CLK_NS = 5;
	localparam int WAKE_MAX_NS = 10000;
	localparam int WAKE_MAX_CYC = WAKE_MAX_NS / CLK_NS;
	localparam int RC_START_CYC = 8;
	localparam int RESYNC_CYC = 3;
	localparam int DEBOUNCE_CYC = 32;
	localparam int REG_START_US = 300;
	localparam int REG_START_CYC = REG_START_US * 1000 / CLK_NS;
	typedef enum logic [1:0] {
		FL_STANDBY = 2'h0,
		FL_DEEP_PD = 2'h1,
		FL_IDLE = 2'h2,
		FL_ACTIVE = 2'h3
	} lps_flash_t;
	typedef struct packed {
		logic usb;
		logic real_time_timer;
		logic rtc;
		logic supply_monitor;
		logic [15:0] pins;
	} lps_wake_t;
	typedef struct packed {
		logic core_reg_en;
		logic core_supply_en;
		logic sram_supply_en;
		logic core_clk_en;
		logic mem_clk_en;
		logic core_rst;
		logic io_hold;
		logic io_default_load;
	} lps_pwr_t;
endpackage

/* core/lps_sequencer.sv */
/*
 Low-power mode sequencer: backup, wait and sleep entry and exit,
 clock and supply gating, flash low-power select, APB registers.
 Assumes wake inputs are asynchronous and active low, and that
 the core signals come from logic on ref_clk.
*/
// The implementer's own choices: the APB interface to the registers and the address map.
`timescale 1ns/1ps
module lps_sequencer #(
	parameter int REG_START = lps_pkg::REG_START_CYC
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic srst,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Core side
	input wire logic deep_sleep_select,
	input wire logic wfi_exec,
	input wire logic irq_pending,
	// Wake sources, active low
	input wire lps_pkg::lps_wake_t wake_n,
	// Power, clock and flash control
	output lps_pkg::lps_pwr_t pwr,
	output logic [15:0] periph_clk_en,
	output lps_pkg::lps_flash_t flash_mode,
	output logic [7:0] osc_cfg,
	output logic master_clock_ready
);
	typedef enum logic [6:0] {
		ST_ACTIVE = 7'b0000001,
		ST_SLEEP = 7'b0000010,
		ST_WAIT_SYNC = 7'b0000100,
		ST_WAIT = 7'b0001000,
		ST_BACKUP = 7'b0010000,
		ST_RESTART_FAST = 7'b0100000,
		ST_RESTART_BKP = 7'b1000000
	} lps_state_t;

	lps_state_t state, next_state;
	lps_pkg::lps_wake_t wake_s1, wake_s2, wake_en, fast_en, snap;
	lps_pkg::lps_wake_t last_wake;
	logic deb_en, low_power_select, reg_disable, regulator_off_request;
	logic [1:0] flash_low_power_select;
	logic [16:0] cnt;
	logic [5:0] deb_cnt;
	logic [15:0] pin_diff;
	logic pin_wake, bkp_wake, fast_hit, wr, setup;

	// All checks sample on ref_clk and rest while in reset
	default clocking @(posedge ref_clk);
	endclocking
	default disable iff (srst);

	// Register index of the current address, used by writes; reads decode the full address
	function automatic logic [2:0] reg_idx(input logic [7:0] a);
		reg_idx = a[4:2];
	endfunction

	// Two flops on every asynchronous wake line
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			wake_s1 <= '1;
			wake_s2 <= '1;
		end else begin
			wake_s1 <= wake_n;
			wake_s2 <= wake_s1;
		end
	end

	// Refused transfers (unaligned, unmapped) must not write
	assign wr = psel && penable && pready && pwrite && !pslverr;
	assign setup = psel && !penable;

	// Fast startup: low level on an enabled source
	assign fast_hit = |(~wake_s2 & fast_en); // see [R21]

	// Pins compared against their level at backup entry
	assign pin_diff = (wake_s2.pins ^ snap.pins) & wake_en.pins;
	assign pin_wake = |pin_diff &&
		(!deb_en || deb_cnt == 6'(lps_pkg::DEBOUNCE_CYC - 1));
	assign bkp_wake = pin_wake ||
		(!wake_s2.supply_monitor && wake_en.supply_monitor) ||
		(!wake_s2.rtc && wake_en.rtc) ||
		(!wake_s2.real_time_timer && wake_en.real_time_timer); // see [R04]

	// Debounce counter restarts whenever pins match again
	always_ff @(posedge ref_clk) begin
		if (srst || !(|pin_diff) || state != ST_BACKUP) begin
			deb_cnt <= '0;
		end else if (!pin_wake) begin
			deb_cnt <= deb_cnt + 6'h01;
		end
	end

	// Mode transitions
	always_comb begin
		next_state = state;
		unique case (state)
			ST_ACTIVE: begin
				if (regulator_off_request && deep_sleep_select) begin
					next_state = ST_BACKUP; // see [R01]
				end else if (osc_cfg[lps_pkg::WAIT_REQ_POS] &&
					low_power_select && !flash_low_power_select[1]) begin
					next_state = ST_WAIT_SYNC; // see [R08]
				end else if (wfi_exec && !low_power_select &&
					!deep_sleep_select) begin
					next_state = ST_SLEEP; // see [R16]
				end
			end
			ST_SLEEP: begin
				if (irq_pending) begin
					next_state = ST_ACTIVE; // see [R17]
				end else if (fast_hit) begin
					next_state = ST_RESTART_FAST;
				end
			end
			ST_WAIT_SYNC: begin
				if (cnt == 17'(lps_pkg::RESYNC_CYC - 1)) begin
					next_state = ST_WAIT;
				end
			end
			ST_WAIT: begin
				if (fast_hit) begin
					next_state = ST_RESTART_FAST; // see [R13]
				end
			end
			ST_BACKUP: begin
				if (bkp_wake) begin
					next_state = ST_RESTART_BKP;
				end
			end
			ST_RESTART_FAST: begin
				if (cnt == 17'(lps_pkg::RC_START_CYC - 1)) begin
					next_state = ST_ACTIVE; // see [R22]
				end
			end
			ST_RESTART_BKP: begin
				if (cnt == 17'(REG_START - 1)) begin
					next_state = ST_ACTIVE;
				end
			end
			default: next_state = ST_ACTIVE;
		endcase
	end

	// State and sequence timer
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			state <= ST_ACTIVE;
			cnt <= '0;
		end else begin
			state <= next_state;
			cnt <= (state != next_state) ? '0 : cnt + 17'h00001;
		end
	end

	// Pin snapshot and wake cause, taken at entry and exit
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			snap <= '1;
			last_wake <= '0;
		end else begin
			if (next_state == ST_BACKUP && state != ST_BACKUP) begin
				snap <= wake_s2;
			end
			if (next_state == ST_RESTART_FAST ||
				next_state == ST_RESTART_BKP) begin
				last_wake <= ~wake_s2;
			end
		end
	end

	// Supply controller registers; request clears on backup entry
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			regulator_off_request <= 1'b0;
			reg_disable <= 1'b0;
			wake_en <= '0;
			deb_en <= 1'b0;
		end else begin
			if (wr && reg_idx(paddr) == reg_idx(lps_pkg::OFS_SUPPLY_CMD)
				&& pwdata[31:lps_pkg::KEY_POS] == lps_pkg::SUPPLY_KEY) begin
				regulator_off_request <=
					pwdata[lps_pkg::REG_OFF_POS]; // see [R02]
			end
			if (next_state == ST_BACKUP) begin
				regulator_off_request <= 1'b0;
			end
			if (wr && reg_idx(paddr) == reg_idx(lps_pkg::OFS_SUPPLY_MODE)) begin
				reg_disable <= pwdata[0];
			end
			if (wr && reg_idx(paddr) == reg_idx(lps_pkg::OFS_WAKE_EN)) begin
				wake_en <= pwdata[19:0];
				deb_en <= pwdata[lps_pkg::DEBOUNCE_POS];
			end
		end
	end

	// Power manager registers; hardware updates win over writes
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			fast_en <= '0;
			low_power_select <= 1'b0;
			flash_low_power_select <= 2'h0;
			osc_cfg <= lps_pkg::OSC_RESET;
			periph_clk_en <= '0;
		end else begin
			if (wr && reg_idx(paddr) == reg_idx(lps_pkg::OFS_FAST_CFG)) begin
				fast_en <= pwdata[19:0];
				low_power_select <= pwdata[lps_pkg::LOW_POWER_POS];
				flash_low_power_select <=
					pwdata[lps_pkg::FLASH_SEL_POS +: 2];
			end
			if (wr && reg_idx(paddr) == reg_idx(lps_pkg::OFS_OSC_CFG)) begin
				osc_cfg <= pwdata[7:0]; // see [R18]
			end
			if (wr && reg_idx(paddr) ==
				reg_idx(lps_pkg::OFS_PERIPH_GATE)) begin
				periph_clk_en <= pwdata[15:0]; // see [R18]
			end
			if (next_state == ST_WAIT) begin
				osc_cfg[0] <= 1'b0; // see [R11]
			end
			if (next_state == ST_ACTIVE &&
				(state == ST_RESTART_FAST || state == ST_RESTART_BKP)) begin
				osc_cfg[0] <= 1'b1;
				osc_cfg[lps_pkg::WAIT_REQ_POS] <= 1'b0;
				osc_cfg[lps_pkg::CLK_SRC_POS +: 2] <=
					lps_pkg::SRC_FAST_RC; // see [R19]
				osc_cfg[lps_pkg::PLL_EN_POS] <= 1'b0; // see [R19]
			end
		end
	end

	// Clock, supply and I/O control from the coming state
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			pwr <= '{core_reg_en: 1'b1, core_supply_en: 1'b1,
				sram_supply_en: 1'b1, core_clk_en: 1'b1,
				mem_clk_en: 1'b1, default: 1'b0};
			master_clock_ready <= 1'b1;
		end else begin
			pwr.core_reg_en <= next_state != ST_BACKUP &&
				!reg_disable; // see [R03] [R20]
			pwr.core_supply_en <= next_state != ST_BACKUP; // see [R07]
			pwr.sram_supply_en <= next_state != ST_BACKUP; // see [R07]
			pwr.core_clk_en <= next_state == ST_ACTIVE; // see [R15]
			pwr.mem_clk_en <= next_state == ST_ACTIVE ||
				next_state == ST_SLEEP; // see [R09]
			pwr.core_rst <= next_state == ST_BACKUP ||
				next_state == ST_RESTART_BKP; // see [R06]
			pwr.io_hold <= next_state == ST_BACKUP; // see [R05]
			pwr.io_default_load <= state == ST_RESTART_BKP &&
				next_state == ST_ACTIVE; // see [R06]
			master_clock_ready <= next_state == ST_ACTIVE ||
				next_state == ST_SLEEP;
		end
	end

	// Flash follows the select field only while in wait
	always_ff @(posedge ref_clk) begin
		if (srst || next_state != ST_WAIT) begin
			flash_mode <= lps_pkg::FL_ACTIVE;
		end else begin
			flash_mode <= lps_pkg::lps_flash_t'(
				flash_low_power_select); // see [R12]
		end
	end

	// Peripheral gate mask is set only in active and sleep; it does not gate periph_clk_en
	logic [15:0] periph_gate_q;
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			periph_gate_q <= '0;
		end else begin
			periph_gate_q <= (next_state == ST_ACTIVE ||
				next_state == ST_SLEEP) ? 16'hFFFF : 16'h0000; // see [R09]
		end
	end

	// APB: zero-wait answer in the cycle after setup
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= '0;
		end else begin
			pready <= setup;
			pslverr <= setup && (paddr[1:0] != 2'h0 ||
				paddr > lps_pkg::OFS_STATUS);
			prdata <= '0;
			if (setup && !pwrite) begin
				unique case (paddr)
					lps_pkg::OFS_SUPPLY_MODE: prdata <= {31'h0, reg_disable};
					lps_pkg::OFS_WAKE_EN: prdata <= {11'h0, deb_en, wake_en};
					lps_pkg::OFS_FAST_CFG: prdata <= {9'h0,
						flash_low_power_select, low_power_select, fast_en};
					lps_pkg::OFS_OSC_CFG: prdata <= {24'h0, osc_cfg};
					lps_pkg::OFS_PERIPH_GATE: prdata <= {16'h0, periph_clk_en};
					lps_pkg::OFS_STATUS: prdata <= {last_wake, 4'h0,
						state, master_clock_ready};
					default: prdata <= '0;
				endcase
			end
		end
	end

	// Resume timer: from a wake seen in wait until the core clock is back;
	// a counter, since the limit is far too long for a delay range
	logic [11:0] wait_cyc;
	always_ff @(posedge ref_clk) begin
		if (srst || pwr.core_clk_en) begin
			wait_cyc <= '0;
		end else if (wait_cyc != 12'h000 ||
			(state == ST_WAIT && fast_hit)) begin
			wait_cyc <= wait_cyc + 12'h001;
		end
	end

	a_key_gate: assert property (wr && // see [R02]
		paddr == lps_pkg::OFS_SUPPLY_CMD &&
		pwdata[31:lps_pkg::KEY_POS] != lps_pkg::SUPPLY_KEY &&
		next_state != ST_BACKUP |=> $stable(regulator_off_request))
		else $error("keyless write changed request");
	a_backup_off: assert property (state == ST_BACKUP |-> // see [R03]
		!pwr.core_reg_en && !pwr.core_supply_en && pwr.io_hold)
		else $error("supply or hold wrong in backup");
	a_backup_exit: assert property (state == ST_BACKUP && // see [R04]
		bkp_wake |=> state == ST_RESTART_BKP)
		else $error("backup wake missed");
	a_wake_reset: assert property (state == ST_RESTART_BKP && // see [R06]
		next_state == ST_ACTIVE |=> pwr.io_default_load &&
		!pwr.core_rst ##1 !pwr.io_default_load)
		else $error("backup wake reset sequence wrong");
	a_wait_entry: assert property (state == ST_ACTIVE && // see [R08]
		osc_cfg[1] && low_power_select && !flash_low_power_select[1] &&
		!regulator_off_request |=> ##3 state == ST_WAIT)
		else $error("wait not entered");
	a_wait_clocks: assert property (state == ST_WAIT |-> // see [R09]
		!pwr.core_clk_en && !pwr.mem_clk_en &&
		periph_gate_q == 16'h0000 && pwr.core_supply_en)
		else $error("clocks running in wait");
	a_wait_resume: assert property ( // see [R14]
		wait_cyc < 12'(lps_pkg::WAKE_MAX_CYC - 2))
		else $error("wait resume too slow");
	a_resume_count: assert property ( // see [R14]
		state == ST_RESTART_FAST |-> wait_cyc <= 12'(lps_pkg::RC_START_CYC))
		else $error("fast restart overran");
	a_sleep_clocks: assert property (state == ST_SLEEP |-> // see [R15]
		!pwr.core_clk_en && pwr.mem_clk_en)
		else $error("sleep gating wrong");
	a_sleep_irq: assert property (state == ST_SLEEP && // see [R17]
		irq_pending |=> ##1 pwr.core_clk_en)
		else $error("interrupt did not wake sleep");
	a_rc_after: assert property ($rose(master_clock_ready) && // see [R19]
		$past(state) == ST_RESTART_FAST |-> osc_cfg[3:2] == 2'h0 &&
		!osc_cfg[4] && osc_cfg[0])
		else $error("not on fast RC after wake");
	c_backup: cover property (@(posedge ref_clk)
		state == ST_RESTART_BKP ##1 state == ST_ACTIVE);
	c_wait: cover property (@(posedge ref_clk)
		state == ST_WAIT ##1 state == ST_RESTART_FAST);
	c_sleep: cover property (@(posedge ref_clk)
		state == ST_SLEEP ##1 state == ST_ACTIVE);
endmodule

/* test/lps_far_model.sv */
/*
 Far-side model: processor core and wake sources facing the sequencer.
 Assumes the bench raises each request just after a rising edge.
*/
`timescale 1ns/1ps
module lps_far_model (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic srst,
	// Requests from the bench
	input wire logic deep_req,
	input wire logic wfi_req,
	input wire logic irq_req,
	input wire lps_pkg::lps_wake_t wake_req,
	// Toward the sequencer
	output logic deep_sleep_select,
	output logic wfi_exec,
	output logic irq_pending,
	output lps_pkg::lps_wake_t wake_n
);
	// Core mode bit is set before the keyed write
	always_ff @(posedge ref_clk) begin
		deep_sleep_select <= deep_req & ~srst;
	end
	// Pending interrupt held until the bench clears it
	always_ff @(posedge ref_clk) begin
		irq_pending <= irq_req & ~srst;
	end
	// One pulse per instruction, never a level
	always_ff @(posedge ref_clk) begin
		wfi_exec <= wfi_req & ~wfi_exec & ~srst;
	end
	// Released wake lines return to their pull-up level
	always_ff @(posedge ref_clk) begin
		wake_n <= srst ? '1 : ~wake_req;
	end
endmodule

/* test/lps_sequencer_tb_top.sv */
/*
 Bench for the low-power mode sequencer: APB master and scenarios.
 Assumes the far-side model drives the core and wake inputs.
*/
`timescale 1ns/1ps
module lps_sequencer_tb_top;
	logic ref_clk = 0;
	logic srst = 1;
	logic psel = 0, penable = 0, pwrite = 0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rdat;
	logic pready, pslverr, rerr;
	logic deep_req = 0, wfi_req = 0, irq_req = 0;
	lps_pkg::lps_wake_t wake_req = '0;
	lps_pkg::lps_wake_t wake_n;
	logic deep_sleep_select, wfi_exec, irq_pending;
	lps_pkg::lps_pwr_t pwr;
	logic [15:0] periph_clk_en;
	lps_pkg::lps_flash_t flash_mode;
	logic [7:0] osc_cfg;
	logic master_clock_ready;
	int err_count = 0, cmp_count = 0, cyc = 0, loads = 0, n;

	// Clock
	always #2.5 ref_clk = ~ref_clk;

	lps_sequencer #(.REG_START(20)) DUT (.ref_clk(ref_clk), .srst(srst),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .deep_sleep_select(deep_sleep_select),
		.wfi_exec(wfi_exec), .irq_pending(irq_pending), .wake_n(wake_n),
		.pwr(pwr), .periph_clk_en(periph_clk_en), .flash_mode(flash_mode),
		.osc_cfg(osc_cfg), .master_clock_ready(master_clock_ready));

	lps_far_model FAR (.ref_clk(ref_clk), .srst(srst),
		.deep_req(deep_req), .wfi_req(wfi_req), .irq_req(irq_req),
		.wake_req(wake_req), .deep_sleep_select(deep_sleep_select),
		.wfi_exec(wfi_exec), .irq_pending(irq_pending), .wake_n(wake_n));

	// Pulse counter; a missed or doubled pulse shows in the total
	always @(posedge ref_clk) begin
		if (pwr.io_default_load === 1'b1) loads++;
	end
	// Hang guard, well above the whole run
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 20000) begin
			err_count++;
			give_verdict;
		end
	end

	task chk(input string nm, input logic [31:0] seen, exp);
		cmp_count++;
		if (seen !== exp) begin
			err_count++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task give_verdict;
		$display("Comparisons %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask

	// One APB transfer; held until pready is seen at an edge
	task apb(input logic [7:0] a, input logic w, input logic [31:0] d);
		@(posedge ref_clk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1;
		do begin
			@(posedge ref_clk);
		end while (pready !== 1'b1);
		rdat = prdata;
		rerr = pslverr;
		psel <= 0;
		penable <= 0;
	endtask

	function automatic logic sig(input int k);
		case (k)
			0: return pwr.core_clk_en;
			1: return pwr.io_hold;
			2: return pwr.core_rst;
			default: return osc_cfg[0];
		endcase
	endfunction

	// Bounded wait for one watched output to reach a level
	task till(input int k, input logic v, input int lim);
		n = 0;
		while (sig(k) !== v && n < lim) begin
			@(posedge ref_clk);
			n++;
		end
	endtask

	task t_reset;
		chk("pwr", pwr, 32'hF8);
		chk("flash", flash_mode, 32'h3);
		chk("osc", osc_cfg, 32'h01);
		chk("ready", master_clock_ready, 32'h1);
		$display("reset test done");
	endtask

	// The misaligned write would hit the regulator disable bit if taken
	task t_apb;
		apb(lps_pkg::OFS_PERIPH_GATE, 1, 32'h0000A5C3);
		@(posedge ref_clk);
		chk("gate", periph_clk_en, 32'hA5C3);
		apb(8'h1C, 0, 32'h0);
		chk("err", rerr, 32'h1);
		chk("rd", rdat, 32'h0);
		apb(8'h06, 1, 32'hFFFFFFFF);
		chk("err", rerr, 32'h1);
		repeat (2) @(posedge ref_clk);
		chk("refused", pwr.core_reg_en, 32'h1);
		$display("apb test done");
	endtask

	// Register bit lands at the write edge, the output one edge later
	task t_regoff;
		apb(lps_pkg::OFS_SUPPLY_MODE, 1, 32'h1);
		repeat (2) @(posedge ref_clk);
		chk("reg", pwr.core_reg_en, 32'h0);
		apb(lps_pkg::OFS_STATUS, 0, 32'h0);
		chk("active", rdat[1], 32'h1);
		apb(lps_pkg::OFS_SUPPLY_MODE, 1, 32'h0);
		repeat (2) @(posedge ref_clk);
		chk("reg", pwr.core_reg_en, 32'h1);
		$display("regulator test done");
	endtask

	// Pin wake with debounce on; the load pulse is counted one edge later
	task t_backup;
		deep_req <= 1;
		apb(lps_pkg::OFS_WAKE_EN, 1, 32'h00100008);
		apb(lps_pkg::OFS_SUPPLY_CMD, 1, 32'h00000004);
		repeat (6) @(posedge ref_clk);
		chk("nokey", pwr.io_hold, 32'h0);
		apb(lps_pkg::OFS_SUPPLY_CMD, 1, 32'hA5000004);
		till(1, 1, 10);
		deep_req <= 0;
		chk("regoff", pwr[7:6], 32'h0);
		repeat (40) @(posedge ref_clk);
		chk("hold", pwr.io_hold, 32'h1);
		chk("rst", pwr.core_rst, 32'h1);
		wake_req.pins[3] <= 1;
		till(2, 0, 200);
		@(posedge ref_clk);
		chk("slow", n >= lps_pkg::DEBOUNCE_CYC + 20, 32'h1);
		chk("sup", pwr[7:5], 32'h7);
		chk("hold", pwr.io_hold, 32'h0);
		chk("load", loads, 32'h1);
		chk("osc", osc_cfg[4:2], 32'h0);
		wake_req <= '0;
		$display("backup test done");
	endtask

	task t_wait;
		int b;
		for (int f = 0; f < 2; f++) begin
			b = f ? 19 : 0;
			apb(lps_pkg::OFS_FAST_CFG, 1,
				32'h00100000 | (32'h1 << b) | (32'(f) << 21));
			apb(lps_pkg::OFS_OSC_CFG, 1, 32'h13);
			till(3, 0, 20);
			chk("clk", pwr[4:3], 32'h0);
			chk("sup", pwr[7:5], 32'h7);
			chk("flash", flash_mode, f);
			wake_req <= 20'h1 << b;
			till(0, 1, 2500);
			chk("fast", n < lps_pkg::WAKE_MAX_CYC, 32'h1);
			@(posedge ref_clk);
			chk("osc", osc_cfg[4:0], 32'h01);
			chk("ready", master_clock_ready, 32'h1);
			chk("io", pwr.io_hold, 32'h0);
			wake_req <= '0;
			repeat (5) @(posedge ref_clk);
		end
		apb(lps_pkg::OFS_FAST_CFG, 1, 32'h00500001);
		apb(lps_pkg::OFS_OSC_CFG, 1, 32'h03);
		repeat (8) @(posedge ref_clk);
		chk("idle", pwr.core_clk_en, 32'h1);
		apb(lps_pkg::OFS_OSC_CFG, 1, 32'h01);
		$display("wait test done");
	endtask

	task t_sleep;
		apb(lps_pkg::OFS_FAST_CFG, 1, 32'h0);
		wfi_req <= 1;
		@(posedge ref_clk);
		wfi_req <= 0;
		till(0, 0, 10);
		chk("core", pwr.core_clk_en, 32'h0);
		chk("mem", pwr.mem_clk_en, 32'h1);
		chk("gate", periph_clk_en, 32'hA5C3);
		irq_req <= 1;
		till(0, 1, 10);
		chk("core", pwr.core_clk_en, 32'h1);
		irq_req <= 0;
		$display("sleep test done");
	endtask

	// Main sequence
	initial begin
		repeat (10) @(posedge ref_clk);
		srst <= 0;
		@(posedge ref_clk);
		t_reset;
		t_apb;
		t_regoff;
		t_backup;
		t_wait;
		t_sleep;
		give_verdict;
	end
endmodule
